// *** rtl/hbpwm_decode.sv ***
// Notes on behaviour
// - both inputs low: both bridge outputs released to high impedance.
// - a low, b high: output a low, output b high, coil one energised.
// - a high, b low: output a high, output b low, coil two energised.
// - both inputs high: both outputs low; avoid this with a latching relay.
`timescale 1ns/10ps

module hbpwm_decode
    import hbpwm_pkg::*;
(
    input wire logic clk,                  // 40 MHz clock
    input wire logic rst_b,                // async reset, active low
    input wire hbpwm_ctrl_t ctrl,          // control inputs a and b
    output logic bridge_out_a_o,           // output a level when driven
    output logic bridge_out_a_oe,          // output a enable, low = hi-z
    output logic bridge_out_b_o,           // output b level when driven
    output logic bridge_out_b_oe,          // output b enable, low = hi-z
    output hbpwm_state_t state_ff          // present decode state
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    // index 0 is output a, index 1 is output b
    localparam int HBPWM_HALVES = 2;

    logic [1:0] ctrl_bits;
    hbpwm_state_t nxt_state;
    hbpwm_half_t nxt_half [HBPWM_HALVES];

    // ------------------------------------------------------------
    // input sampling
    // ------------------------------------------------------------
    // input a is the upper bit of the pair
    assign ctrl_bits = {ctrl.ctrl_in_a, ctrl.ctrl_in_b};

    // ------------------------------------------------------------
    // state decode
    // ------------------------------------------------------------
    // purely a function of the present input levels
    always_comb begin
        case (ctrl_bits)
            2'h0: begin
                nxt_state = HBPWM_ST_HIZ;
            end
            2'h1: begin
                nxt_state = HBPWM_ST_RELAY_COIL_ONE;
            end
            2'h2: begin
                nxt_state = HBPWM_ST_RELAY_COIL_TWO;
            end
            2'h3: begin
                nxt_state = HBPWM_ST_BRAKE;
            end
            default: begin
                // unknown inputs: release the bridge rather than guess
                nxt_state = HBPWM_ST_HIZ;
            end
        endcase
    end

    // ------------------------------------------------------------
    // switch table
    // ------------------------------------------------------------
    // no state ever turns on both switches of one half
    always_comb begin
        nxt_half[0].drive_lo = 1'b0;
        nxt_half[0].drive_hi = 1'b0;
        nxt_half[1].drive_lo = 1'b0;
        nxt_half[1].drive_hi = 1'b0;
        case (nxt_state)
            HBPWM_ST_HIZ: begin
                nxt_half[0].drive_lo = 1'b0;
                nxt_half[0].drive_hi = 1'b0;
                nxt_half[1].drive_lo = 1'b0;
                nxt_half[1].drive_hi = 1'b0;
            end
            HBPWM_ST_RELAY_COIL_ONE: begin
                nxt_half[0].drive_lo = 1'b1;
                nxt_half[0].drive_hi = 1'b0;
                nxt_half[1].drive_lo = 1'b0;
                nxt_half[1].drive_hi = 1'b1;
            end
            HBPWM_ST_RELAY_COIL_TWO: begin
                nxt_half[0].drive_lo = 1'b0;
                nxt_half[0].drive_hi = 1'b1;
                nxt_half[1].drive_lo = 1'b1;
                nxt_half[1].drive_hi = 1'b0;
            end
            HBPWM_ST_BRAKE: begin
                nxt_half[0].drive_lo = 1'b1;
                nxt_half[0].drive_hi = 1'b0;
                nxt_half[1].drive_lo = 1'b1;
                nxt_half[1].drive_hi = 1'b0;
            end
            default: begin
                nxt_half[0].drive_lo = 1'b0;
                nxt_half[0].drive_hi = 1'b0;
                nxt_half[1].drive_lo = 1'b0;
                nxt_half[1].drive_hi = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= HBPWM_STATE_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------
    // half-bridge output stages
    // ------------------------------------------------------------
    for (genvar g = 0; g < HBPWM_HALVES; g++) begin : g_half
        logic shoot_through;
        logic nxt_lvl;
        logic nxt_oe;
        logic lvl_ff;
        logic oe_ff;

        // guard against both switches of a half conducting at once
        assign shoot_through = nxt_half[g].drive_hi & nxt_half[g].drive_lo;

        // the level only matters while the stage is enabled
        assign nxt_lvl = nxt_half[g].drive_hi & ~shoot_through;

        // either switch on means the pin is driven
        assign nxt_oe = (nxt_half[g].drive_hi | nxt_half[g].drive_lo) & ~shoot_through;

        // --------------------------------------------------------
        // drive level
        // --------------------------------------------------------
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                lvl_ff <= HBPWM_OUT_RST;
            end else begin
                lvl_ff <= nxt_lvl;
            end
        end

        // --------------------------------------------------------
        // drive enable
        // --------------------------------------------------------
        // enable low leaves the pin released
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                oe_ff <= HBPWM_OE_RST;
            end else begin
                oe_ff <= nxt_oe;
            end
        end
    end : g_half

    // ------------------------------------------------------------
    // port wiring
    // ------------------------------------------------------------
    assign bridge_out_a_o = g_half[0].lvl_ff;
    assign bridge_out_a_oe = g_half[0].oe_ff;
    assign bridge_out_b_o = g_half[1].lvl_ff;
    assign bridge_out_b_oe = g_half[1].oe_ff;

endmodule : hbpwm_decode

// *** rtl/hbpwm_pkg.sv ***
package hbpwm_pkg;

    // ------------------------------------------------------------
    // output drive encoding
    // ------------------------------------------------------------
    typedef struct packed {
        logic drive_lo;   // low-side on
        logic drive_hi;   // high-side on
    } hbpwm_half_t;

    typedef struct packed {
        logic ctrl_in_a;
        logic ctrl_in_b;
    } hbpwm_ctrl_t;

    // ------------------------------------------------------------
    // decode states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        HBPWM_ST_HIZ   = 4'h1,
        HBPWM_ST_RELAY_COIL_ONE = 4'h2,
        HBPWM_ST_RELAY_COIL_TWO = 4'h4,
        HBPWM_ST_BRAKE = 4'h8
    } hbpwm_state_t;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam hbpwm_state_t HBPWM_STATE_RST = HBPWM_ST_HIZ;
    localparam logic HBPWM_OE_RST = 1'h0;
    localparam logic HBPWM_OUT_RST = 1'h0;

endpackage : hbpwm_pkg

// *** tb/hbpwm_monitor.sv ***
`timescale 1ns/10ps
module hbpwm_monitor import hbpwm_pkg::*; (input wire logic clk, // clock
    input wire logic rst_b, // reset
    input wire hbpwm_ctrl_t ctrl, // inputs
    input wire logic bridge_out_a_o, // a
    input wire logic bridge_out_a_oe, // a
    input wire logic bridge_out_b_o, // b
    input wire logic bridge_out_b_oe); // b
    wire logic [3:0] o = {bridge_out_a_oe, bridge_out_a_o, bridge_out_b_oe, bridge_out_b_o};
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    hiz_out_a: assert property (ctrl == 2'h0 |=> o == 4'h0) else $error("hi-z");
    coil_one_a: assert property (ctrl == 2'h1 |=> o == 4'hB) else $error("coil one");
    coil_two_a: assert property (ctrl == 2'h2 |-> ##1 o == 4'hE) else $error("coil two");
    both_low_a: assert property (ctrl == 2'h3 |=> o == 4'hA) else $error("both low");
    no_memory_a: assert property ($stable(ctrl) |=> $stable(o)) else $error("drift");
endmodule : hbpwm_monitor

// *** tb/hbpwm_gpio_model.sv ***
`timescale 1ns/10ps
module hbpwm_gpio_model (input wire logic [1:0] want, // levels wanted
    output logic [1:0] ctrl); // gpio pins
    assign ctrl = want;
endmodule : hbpwm_gpio_model

// *** tb/tb.sv ***
`timescale 1ns/10ps
module tb;
    localparam logic [3:0] EXP [4] = '{4'h0, 4'hB, 4'hE, 4'hA};
    localparam logic [3:0] EXP_ST [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
    logic clk = 1'h0, rst_b = 1'h0;
    logic [1:0] w = 2'h0, c;
    logic [3:0] o;
    logic [3:0] st;
    int n_errors = 0, check_count = 0;
    hbpwm_gpio_model i_gpio (.want(w), .ctrl(c));
    hbpwm_decode i_dut (.clk, .rst_b, .ctrl(c), .bridge_out_a_o(o[2]), .bridge_out_a_oe(o[3]),
        .bridge_out_b_o(o[0]), .bridge_out_b_oe(o[1]), .state_ff(st));
    task automatic cmp_out(input logic [3:0] exp, input logic [3:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error outputs exp %h got %h", exp, got);
        end
    endtask : cmp_out
    task automatic cmp_st(input logic [3:0] exp, input logic [3:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error state exp %h got %h", exp, got);
        end
    endtask : cmp_st
    task automatic step(input logic [1:0] v);
        @(posedge clk) w <= v;
        repeat (2) @(negedge clk);
        cmp_out(EXP[v], o);
        cmp_st(EXP_ST[v], st);
    endtask : step
    task automatic sc_reset;
        step(2'h1);
        @(posedge clk) rst_b <= 1'h0;
        w <= 2'h0;
        @(negedge clk);
        cmp_out(4'h0, o);
        cmp_st(4'h1, st);
        @(posedge clk) rst_b <= 1'h1;
        step(2'h2);
        step(2'h0);
    endtask : sc_reset
    task automatic sc_codes;
        for (int i = 0; i < 8; i++) step(2'(i < 4 ? i : 7 - i));
    endtask : sc_codes
    task automatic conclude;
        if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    initial forever #12.5 clk = ~clk;
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'h1;
        sc_codes;
        sc_reset;
        conclude;
    end
endmodule : tb
bind hbpwm_decode hbpwm_monitor i_mon (.clk, .rst_b, .ctrl, .bridge_out_a_o,
    .bridge_out_a_oe, .bridge_out_b_o, .bridge_out_b_oe);
